// ===== trlot_pkg.sv
package trlot_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int OFFS_W = 9;

  // Register offsets on the control port
  localparam logic [7:0] ADDR_BANDGAP_CTRL = 8'h2c;
  localparam logic [7:0] ADDR_UNLOCK_FIRST = 8'h3f;
  localparam logic [7:0] ADDR_UNLOCK_SECOND = 8'h40;
  localparam logic [7:0] ADDR_TEST_MODE = 8'h41;
  localparam logic [7:0] ADDR_LEFT_DIFF = 8'h46;
  localparam logic [7:0] ADDR_LEFT_CM = 8'h47;
  localparam logic [7:0] ADDR_RIGHT_DIFF = 8'h48;
  localparam logic [7:0] ADDR_RIGHT_CM = 8'h49;
  localparam logic [7:0] ADDR_SPARE_A = 8'h4a;
  localparam logic [7:0] ADDR_SPARE_B = 8'h4b;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_MODE = 4'h0;
  localparam logic [8:0] RST_OFFS = 9'h000;

  // Field positions and widths
  localparam int BANDGAP_ON_BIT = 0;
  localparam int TEST_MODE_W = 4;
  localparam int DIFF_CODE_W = 7;
  localparam int CM_CODE_W = 8;

  // Expected unlock words; values are arbitrary
  localparam logic [7:0] UNLOCK_FIRST_DEF = 8'h5a;
  localparam logic [7:0] UNLOCK_SECOND_DEF = 8'ha5;

  typedef enum logic [3:0] {
    TRLOT_MODE_NORMAL = 4'b0000,
    TRLOT_MODE_SCAN = 4'b0001,
    TRLOT_MODE_IDDQ = 4'b0010,
    TRLOT_MODE_OUT_HIGH = 4'b0011,
    TRLOT_MODE_OUT_LOW = 4'b0100,
    TRLOT_MODE_IN_LOW = 4'b0101,
    TRLOT_MODE_IN_HIGH = 4'b0110,
    TRLOT_MODE_HI_Z = 4'b0111
  } trlot_mode_t;

endpackage : trlot_pkg

// ===== trlot_trim_map.sv
`timescale 1ns/1ns
// Turns a trim code into a signed offset in 0.25 mV steps, positive code giving
// a negative offset. CLAMP folds the most negative code onto the largest
// positive step instead of one step beyond it.
module trlot_trim_map
  import trlot_pkg::*;
#(
  parameter int CODE_W = 7,
  parameter bit CLAMP = 1'b1
) (
  input wire logic [7:0] code,
  output logic signed [8:0] offset
);

  localparam logic signed [8:0] EDGE = 9'(1 << (CODE_W - 1));

  logic signed [8:0] ext;
  logic signed [8:0] neg;

  always_comb begin
    ext = 9'($signed(code[CODE_W-1:0]));
    neg = 9'(-ext);
    if (CLAMP && neg == EDGE) begin
      offset = 9'(EDGE - 9'sd1);
    end else begin
      offset = neg;
    end
  end

endmodule : trlot_trim_map

// ===== trlot_bank.sv
`timescale 1ns/1ns
//
// Behaviour
// - Bandgap bit powers LDO bandgap, test mode only
// - Unlock only when both words match
// - Locked test registers ignore every write
// - Locked test registers read back zero
// - Unlock words at 0x3f, 0x40, reset zero
// - Test mode field decodes eight modes
// - Left diff trim, quarter mV, inverted, 15.75
// - Left common-mode trim, inverted, up to 31.75
// - Right diff trim, inverted, plus/minus 15.75
// - Right common-mode trim, most negative gives 32.0
module trlot_bank
  import trlot_pkg::*;
#(
  parameter logic [7:0] UNLOCK_FIRST_VAL = UNLOCK_FIRST_DEF,
  parameter logic [7:0] UNLOCK_SECOND_VAL = UNLOCK_SECOND_DEF
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  output logic reg_rd_valid,
  output logic test_unlocked,
  output logic [3:0] test_mode,
  output logic mode_scan,
  output logic mode_iddq,
  output logic mode_out_high,
  output logic mode_out_low,
  output logic mode_in_low,
  output logic mode_in_high,
  output logic mode_hi_z,
  output logic bandgap_override,
  output logic bandgap_power_on,
  output logic signed [8:0] offs_left_diff,
  output logic signed [8:0] offs_left_cm,
  output logic signed [8:0] offs_right_diff,
  output logic signed [8:0] offs_right_cm
);

  typedef struct packed {
    logic bandgap_on;
    logic [7:0] unlock_first;
    logic [7:0] unlock_second;
    logic [3:0] mode;
    logic [7:0] left_diff;
    logic [7:0] left_cm;
    logic [7:0] right_diff;
    logic [7:0] right_cm;
    logic [7:0] spare_a;
    logic [7:0] spare_b;
    logic [7:0] rd_data;
    logic rd_valid;
    logic unlocked;
    logic [6:0] mode_flags;
    logic bg_ovr;
    logic bg_on_out;
    logic [8:0] o_ld;
    logic [8:0] o_lc;
    logic [8:0] o_rd;
    logic [8:0] o_rc;
  } trlot_state_t;

  trlot_state_t st_r;
  trlot_state_t st_nxt;

  logic signed [8:0] map_ld;
  logic signed [8:0] map_lc;
  logic signed [8:0] map_rd;
  logic signed [8:0] map_rc;
  logic unlock_match;

  // Everything behind the lock; the unlock words stay reachable so that
  // software can always get in.
  function automatic logic is_test_reg(input logic [7:0] a);
    case (a)
      ADDR_BANDGAP_CTRL, ADDR_TEST_MODE, ADDR_LEFT_DIFF, ADDR_LEFT_CM,
      ADDR_RIGHT_DIFF, ADDR_RIGHT_CM, ADDR_SPARE_A, ADDR_SPARE_B: is_test_reg = 1'b1;
      default: is_test_reg = 1'b0;
    endcase
  endfunction : is_test_reg

  function automatic logic [7:0] read_mux(input trlot_state_t s, input logic [7:0] a);
    case (a)
      ADDR_BANDGAP_CTRL: read_mux = {7'h00, s.bandgap_on};
      ADDR_UNLOCK_FIRST: read_mux = s.unlock_first;
      ADDR_UNLOCK_SECOND: read_mux = s.unlock_second;
      ADDR_TEST_MODE: read_mux = {4'h0, s.mode};
      ADDR_LEFT_DIFF: read_mux = s.left_diff;
      ADDR_LEFT_CM: read_mux = s.left_cm;
      ADDR_RIGHT_DIFF: read_mux = s.right_diff;
      ADDR_RIGHT_CM: read_mux = s.right_cm;
      ADDR_SPARE_A: read_mux = s.spare_a;
      ADDR_SPARE_B: read_mux = s.spare_b;
      default: read_mux = 8'h00;
    endcase
  endfunction : read_mux

  // Compare against the stored words, so the lock follows every access
  assign unlock_match = (st_r.unlock_first == UNLOCK_FIRST_VAL) &&
    (st_r.unlock_second == UNLOCK_SECOND_VAL);

  trlot_trim_map #(.CODE_W(DIFF_CODE_W), .CLAMP(1'b1)) u_map_ld (
    .code(st_r.left_diff),
    .offset(map_ld)
  );
  trlot_trim_map #(.CODE_W(CM_CODE_W), .CLAMP(1'b1)) u_map_lc (
    .code(st_r.left_cm),
    .offset(map_lc)
  );
  trlot_trim_map #(.CODE_W(DIFF_CODE_W), .CLAMP(1'b1)) u_map_rd (
    .code(st_r.right_diff),
    .offset(map_rd)
  );
  // Right common-mode keeps the full step beyond, reaching +32.0 mV
  trlot_trim_map #(.CODE_W(CM_CODE_W), .CLAMP(1'b0)) u_map_rc (
    .code(st_r.right_cm),
    .offset(map_rc)
  );

  always_comb begin
    logic wr_ok;
    wr_ok = 1'b0;
    st_nxt = st_r;
    wr_ok = reg_wr_en && (!is_test_reg(reg_addr) || unlock_match);
    if (wr_ok) begin
      case (reg_addr)
        ADDR_BANDGAP_CTRL: st_nxt.bandgap_on = reg_wr_data[BANDGAP_ON_BIT];
        ADDR_UNLOCK_FIRST: st_nxt.unlock_first = reg_wr_data;
        ADDR_UNLOCK_SECOND: st_nxt.unlock_second = reg_wr_data;
        ADDR_TEST_MODE: st_nxt.mode = reg_wr_data[TEST_MODE_W-1:0];
        ADDR_LEFT_DIFF: st_nxt.left_diff = reg_wr_data;
        ADDR_LEFT_CM: st_nxt.left_cm = reg_wr_data;
        ADDR_RIGHT_DIFF: st_nxt.right_diff = reg_wr_data;
        ADDR_RIGHT_CM: st_nxt.right_cm = reg_wr_data;
        ADDR_SPARE_A: st_nxt.spare_a = reg_wr_data;
        ADDR_SPARE_B: st_nxt.spare_b = reg_wr_data;
        default: st_nxt.spare_b = st_r.spare_b;
      endcase
    end
    // A read in the same cycle as a write returns the old contents
    st_nxt.rd_valid = reg_rd_en;
    if (reg_rd_en) begin
      if (is_test_reg(reg_addr) && !unlock_match) begin
        st_nxt.rd_data = 8'h00;
      end else begin
        st_nxt.rd_data = read_mux(st_r, reg_addr);
      end
    end
    st_nxt.unlocked = unlock_match;
    st_nxt.mode_flags = 7'h00;
    case (trlot_mode_t'(st_r.mode))
      TRLOT_MODE_SCAN: st_nxt.mode_flags[0] = 1'b1;
      TRLOT_MODE_IDDQ: st_nxt.mode_flags[1] = 1'b1;
      TRLOT_MODE_OUT_HIGH: st_nxt.mode_flags[2] = 1'b1;
      TRLOT_MODE_OUT_LOW: st_nxt.mode_flags[3] = 1'b1;
      TRLOT_MODE_IN_LOW: st_nxt.mode_flags[4] = 1'b1;
      TRLOT_MODE_IN_HIGH: st_nxt.mode_flags[5] = 1'b1;
      TRLOT_MODE_HI_Z: st_nxt.mode_flags[6] = 1'b1;
      default: st_nxt.mode_flags = 7'h00;
    endcase
    // Bandgap control only overrides the analog side outside normal mode
    st_nxt.bg_ovr = (st_r.mode != TRLOT_MODE_NORMAL);
    st_nxt.bg_on_out = (st_r.mode != TRLOT_MODE_NORMAL) && st_r.bandgap_on;
    st_nxt.o_ld = map_ld;
    st_nxt.o_lc = map_lc;
    st_nxt.o_rd = map_rd;
    st_nxt.o_rc = map_rc;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st_r <= '0;
      st_r.unlock_first <= RST_BYTE;
      st_r.unlock_second <= RST_BYTE;
      st_r.mode <= RST_MODE;
      st_r.left_diff <= RST_BYTE;
      st_r.left_cm <= RST_BYTE;
      st_r.right_diff <= RST_BYTE;
      st_r.right_cm <= RST_BYTE;
      st_r.o_ld <= RST_OFFS;
      st_r.o_lc <= RST_OFFS;
      st_r.o_rd <= RST_OFFS;
      st_r.o_rc <= RST_OFFS;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rd_data = st_r.rd_data;
  assign reg_rd_valid = st_r.rd_valid;
  assign test_unlocked = st_r.unlocked;
  assign test_mode = st_r.mode;
  assign mode_scan = st_r.mode_flags[0];
  assign mode_iddq = st_r.mode_flags[1];
  assign mode_out_high = st_r.mode_flags[2];
  assign mode_out_low = st_r.mode_flags[3];
  assign mode_in_low = st_r.mode_flags[4];
  assign mode_in_high = st_r.mode_flags[5];
  assign mode_hi_z = st_r.mode_flags[6];
  assign bandgap_override = st_r.bg_ovr;
  assign bandgap_power_on = st_r.bg_on_out;
  assign offs_left_diff = st_r.o_ld;
  assign offs_left_cm = st_r.o_lc;
  assign offs_right_diff = st_r.o_rd;
  assign offs_right_cm = st_r.o_rc;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  a_bandgap_test_only: assert property (
    ##1 (bandgap_power_on |-> ($past(st_r.mode) != 4'h0 && $past(st_r.bandgap_on))))
    else $error("bandgap on outside test mode or without its bit");

  a_unlock_both_words: assert property (
    ##1 (test_unlocked == ($past(st_r.unlock_first) == UNLOCK_FIRST_VAL &&
      $past(st_r.unlock_second) == UNLOCK_SECOND_VAL)))
    else $error("unlock state does not follow both words");

  a_locked_write_held: assert property (
    (reg_wr_en && is_test_reg(reg_addr) && !unlock_match) |=>
      $stable({st_r.bandgap_on, st_r.mode, st_r.left_diff, st_r.left_cm,
        st_r.right_diff, st_r.right_cm, st_r.spare_a, st_r.spare_b}))
    else $error("locked test register changed on write");

  a_locked_read_zero: assert property (
    (reg_rd_en && is_test_reg(reg_addr) && !unlock_match) |=>
      (reg_rd_valid && reg_rd_data == 8'h00))
    else $error("locked test register read not zero");

  a_unlock_word_store: assert property (
    (reg_wr_en && reg_addr == ADDR_UNLOCK_SECOND) |=> st_r.unlock_second == $past(reg_wr_data))
    else $error("second unlock word not stored");

  a_mode_iddq_decode: assert property (
    ##1 (mode_iddq == ($past(st_r.mode) == 4'h2) && mode_hi_z == ($past(st_r.mode) == 4'h7)))
    else $error("test mode decode wrong");

  a_left_diff_top: assert property (
    (st_r.left_diff[6:0] == 7'h3f) |=> offs_left_diff == -9'sd63)
    else $error("left diff trim does not give -15.75 mV");

  a_left_cm_edge: assert property (
    (st_r.left_cm == 8'h80) |=> offs_left_cm == 9'sd127)
    else $error("left common-mode trim not capped at 31.75 mV");

  a_right_diff_edge: assert property (
    (st_r.right_diff[6:0] == 7'h41) |=> offs_right_diff == 9'sd63)
    else $error("right diff trim does not give 15.75 mV");

  a_right_cm_edge: assert property (
    (st_r.right_cm == 8'h80) |=> offs_right_cm == 9'sd128)
    else $error("right common-mode trim does not give 32.0 mV");

  a_bandgap_override: assert property (
    ##1 (bandgap_override == ($past(st_r.mode) != 4'h0)))
    else $error("bandgap override does not follow test mode");

  a_expected_words: assert property (
    (st_r.unlock_first == UNLOCK_FIRST_VAL && st_r.unlock_second == UNLOCK_SECOND_VAL) |=>
      test_unlocked)
    else $error("expected unlock words did not unlock");

  // An accepted write must land, or the lock would look stuck to software
  a_open_write_lands: assert property (
    (reg_wr_en && reg_addr == ADDR_LEFT_CM && unlock_match) |=>
      st_r.left_cm == $past(reg_wr_data))
    else $error("unlocked trim write lost");

  a_open_read_data: assert property (
    (reg_rd_en && reg_addr == ADDR_RIGHT_CM && unlock_match) |=>
      reg_rd_data == $past(st_r.right_cm))
    else $error("unlocked read does not return stored trim");

  a_read_valid_pulse: assert property (
    ##1 (reg_rd_valid == $past(reg_rd_en)))
    else $error("read valid not one cycle after strobe");

  a_first_word_store: assert property (
    (reg_wr_en && reg_addr == ADDR_UNLOCK_FIRST) |=>
      st_r.unlock_first == $past(reg_wr_data))
    else $error("first unlock word not stored");

  a_mode_out_decode: assert property (
    ##1 (mode_scan == ($past(st_r.mode) == 4'h1) &&
      mode_out_high == ($past(st_r.mode) == 4'h3) &&
      mode_out_low == ($past(st_r.mode) == 4'h4)))
    else $error("scan or output test mode decode wrong");

  a_mode_in_decode: assert property (
    ##1 (mode_in_low == ($past(st_r.mode) == 4'h5) &&
      mode_in_high == ($past(st_r.mode) == 4'h6)))
    else $error("input test mode decode wrong");

  a_left_diff_bottom: assert property (
    (st_r.left_diff[6:0] == 7'h41) |=> offs_left_diff == 9'sd63)
    else $error("left diff trim does not give 15.75 mV");

  a_left_cm_top: assert property (
    (st_r.left_cm == 8'h7f) |=> offs_left_cm == -9'sd127)
    else $error("left common-mode trim does not give -31.75 mV");

  a_right_diff_top: assert property (
    (st_r.right_diff[6:0] == 7'h3f) |=> offs_right_diff == -9'sd63)
    else $error("right diff trim does not give -15.75 mV");

  a_right_cm_step: assert property (
    (st_r.right_cm == 8'h81) |=> offs_right_cm == 9'sd127)
    else $error("right common-mode trim does not give 31.75 mV");

endmodule : trlot_bank

// ===== trlot_host.sv
`timescale 1ns/1ns
// Control-port host: one strobe per byte, changed only at the falling edge
module trlot_host (
  input wire logic ref_clk,
  input wire logic reg_rd_valid,
  input wire logic [7:0] reg_rd_data,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wr_data
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wr_data = 8'h00;
  end

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wr_data = d;
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
    // Idle bus shows inverted leftovers so a stale sample cannot pass
    reg_addr = ~a;
    reg_wr_data = ~d;
  endtask : write_reg

  // Read data is due exactly one cycle after the strobe
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge ref_clk);
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    ok = reg_rd_valid;
    d = reg_rd_data;
  endtask : read_reg
endmodule : trlot_host

// ===== test_register_lock_and_offset_trim_bench.sv
`timescale 1ns/1ns
module test_register_lock_and_offset_trim_bench;
  import trlot_pkg::*;
  logic ref_clk, rst_b, wr_en, rd_en, rd_valid, unlocked, bg_ovr, bg_on;
  logic [7:0] addr, wr_data, rd_data;
  logic [3:0] mode;
  wire [6:0] onehot;
  logic signed [8:0] o_ld, o_lc, o_rd, o_rc;
  int n_errors = 0;
  int samples_checked = 0;

  trlot_host host (.ref_clk(ref_clk), .reg_rd_valid(rd_valid), .reg_rd_data(rd_data),
    .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr), .reg_wr_data(wr_data));
  trlot_bank dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr(addr), .reg_wr_data(wr_data), .reg_rd_data(rd_data), .reg_rd_valid(rd_valid),
    .test_unlocked(unlocked), .test_mode(mode), .mode_scan(onehot[0]),
    .mode_iddq(onehot[1]), .mode_out_high(onehot[2]), .mode_out_low(onehot[3]),
    .mode_in_low(onehot[4]), .mode_in_high(onehot[5]), .mode_hi_z(onehot[6]),
    .bandgap_override(bg_ovr), .bandgap_power_on(bg_on), .offs_left_diff(o_ld),
    .offs_left_cm(o_lc), .offs_right_diff(o_rd), .offs_right_cm(o_rc));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic give_verdict;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.read_reg(a, d, ok);
    chk("read valid", {8'h00, ok}, 9'h001);
    chk($sformatf("read data at %h", a), {1'b0, d}, {1'b0, exp});
  endtask : rd_chk

  task automatic settle;
    repeat (2) @(negedge ref_clk);
  endtask : settle

  task automatic unlock(input logic [7:0] w1, input logic [7:0] w2);
    host.write_reg(ADDR_UNLOCK_FIRST, w1);
    host.write_reg(ADDR_UNLOCK_SECOND, w2);
    settle();
  endtask : unlock

  task automatic t_reset_locked;
    rd_chk(ADDR_UNLOCK_FIRST, 8'h00);
    rd_chk(ADDR_UNLOCK_SECOND, 8'h00);
    host.write_reg(ADDR_LEFT_DIFF, 8'h11);
    host.write_reg(ADDR_SPARE_A, 8'h3c);
    rd_chk(ADDR_LEFT_DIFF, 8'h00);
    chk("unlocked", {8'h00, unlocked}, 9'h000);
  endtask : t_reset_locked

  task automatic t_wrong_words;
    unlock(UNLOCK_FIRST_DEF, 8'ha4);
    chk("unlocked second wrong", {8'h00, unlocked}, 9'h000);
    unlock(8'h5b, UNLOCK_SECOND_DEF);
    chk("unlocked first wrong", {8'h00, unlocked}, 9'h000);
    rd_chk(ADDR_UNLOCK_FIRST, 8'h5b);
  endtask : t_wrong_words

  task automatic t_unlock_and_modes;
    unlock(UNLOCK_FIRST_DEF, UNLOCK_SECOND_DEF);
    chk("unlocked", {8'h00, unlocked}, 9'h001);
    rd_chk(ADDR_LEFT_DIFF, 8'h00);
    rd_chk(ADDR_SPARE_A, 8'h00);
    host.write_reg(ADDR_BANDGAP_CTRL, 8'hff);
    for (int m = 0; m < 8; m++) begin
      host.write_reg(ADDR_TEST_MODE, 8'hf0 | 8'(m));
      settle();
      chk("test mode", {5'h00, mode}, 9'(m));
      chk("mode decode", {2'b00, onehot}, (m == 0) ? 9'h000 : 9'(1 << (m - 1)));
      chk("bandgap on", {8'h00, bg_on}, {8'h00, m != 0});
      chk("bandgap override", {8'h00, bg_ovr}, {8'h00, m != 0});
      rd_chk(ADDR_TEST_MODE, 8'(m));
    end
    rd_chk(ADDR_BANDGAP_CTRL, 8'h01);
    host.write_reg(ADDR_BANDGAP_CTRL, 8'h00);
    settle();
    chk("bandgap off", {8'h00, bg_on}, 9'h000);
  endtask : t_unlock_and_modes

  task automatic trim(input logic [7:0] a, input logic [7:0] c, input logic [8:0] e);
    logic [8:0] got;
    host.write_reg(a, c);
    settle();
    case (a)
      ADDR_LEFT_DIFF: got = o_ld;
      ADDR_LEFT_CM: got = o_lc;
      ADDR_RIGHT_DIFF: got = o_rd;
      default: got = o_rc;
    endcase
    chk($sformatf("offset at %h", a), got, e);
    rd_chk(a, c);
  endtask : trim

  task automatic t_trims;
    trim(ADDR_LEFT_DIFF, 8'h3f, -9'sd63);
    trim(ADDR_LEFT_DIFF, 8'h41, 9'sd63);
    trim(ADDR_LEFT_DIFF, 8'h40, 9'sd63);
    trim(ADDR_LEFT_CM, 8'h80, 9'sd127);
    trim(ADDR_LEFT_CM, 8'h7f, -9'sd127);
    trim(ADDR_RIGHT_DIFF, 8'h7f, 9'sd1);
    trim(ADDR_RIGHT_DIFF, 8'h3f, -9'sd63);
    trim(ADDR_RIGHT_DIFF, 8'hc1, 9'sd63);
    trim(ADDR_RIGHT_CM, 8'h80, 9'sd128);
    trim(ADDR_RIGHT_CM, 8'h81, 9'sd127);
    host.write_reg(ADDR_SPARE_B, 8'ha6);
    rd_chk(ADDR_SPARE_B, 8'ha6);
  endtask : t_trims

  task automatic t_relock;
    unlock(UNLOCK_FIRST_DEF, 8'h00);
    rd_chk(ADDR_RIGHT_CM, 8'h00);
    host.write_reg(ADDR_RIGHT_CM, 8'h22);
    settle();
    chk("offset kept", o_rc, 9'sd127);
    unlock(UNLOCK_FIRST_DEF, UNLOCK_SECOND_DEF);
    rd_chk(ADDR_RIGHT_CM, 8'h81);
  endtask : t_relock

  // Reset in mid-run must clear words, lock, mode and trims
  task automatic t_mid_reset;
    @(negedge ref_clk);
    rst_b = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_b = 1'b1;
    chk("unlocked after reset", {8'h00, unlocked}, 9'h000);
    chk("offset after reset", o_rc, 9'h000);
    chk("mode after reset", {5'h00, mode}, 9'h000);
    rd_chk(ADDR_UNLOCK_FIRST, 8'h00);
    unlock(UNLOCK_FIRST_DEF, UNLOCK_SECOND_DEF);
    chk("unlocked again", {8'h00, unlocked}, 9'h001);
    rd_chk(ADDR_RIGHT_CM, 8'h00);
    rd_chk(ADDR_BANDGAP_CTRL, 8'h00);
  endtask : t_mid_reset

  initial begin
    rst_b = 1'b0;
    repeat (3) @(negedge ref_clk);
    rst_b = 1'b1;
    t_reset_locked();
    t_wrong_words();
    t_unlock_and_modes();
    t_trims();
    t_relock();
    t_mid_reset();
    give_verdict();
  end

  // A hung run is cut short and counted as a failure
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    give_verdict();
  end
endmodule : test_register_lock_and_offset_trim_bench
